// [inc/smux_pkg.sv]
// Constants, register map and types for the sample multiplex formatter
package smux_pkg;
  // Datapath shape
  localparam int SAMPLE_W = 24;
  localparam int NUM_CH = 8;
  localparam int OPT_SLOTS = 8;
  localparam int AES_LINES = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int MAX_GROUP = 4;

  // Clock and base frame rates
  localparam int CLK_HZ = 200_000_000;
  localparam int BASE_441_HZ = 44_100;
  localparam int BASE_48_HZ = 48_000;
  localparam int CYC_441 = CLK_HZ / BASE_441_HZ;
  localparam int CYC_48 = CLK_HZ / BASE_48_HZ;

  // Speed modes
  typedef enum logic [1:0] {
    SPEED_SINGLE = 2'b00,
    SPEED_DOUBLE = 2'b01,
    SPEED_QUAD = 2'b10
  } speed_t;

  // APB byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CSTAT = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;

  // Control register fields
  localparam int CTRL_SPEED = 0;
  localparam int CTRL_BASE48 = 2;
  localparam int CTRL_DWIRE = 3;
  localparam int CTRL_EN = 4;
  localparam int CTRL_MADI64 = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  // Channel-status source register fields
  localparam int CS_PRO = 0;
  localparam int CS_NONAUDIO = 1;
  localparam int CS_PEMPH = 2;
  localparam int CS_PLOCK = 5;
  localparam int CS_PFREQ = 6;
  localparam int CS_CCOPY = 8;
  localparam int CS_CEMPH = 9;
  localparam int CS_CMODE = 12;
  localparam logic [13:0] CSTAT_RESET = 14'h0000;

  // Status register fields
  localparam int ST_COUNT = 0;
  localparam int ST_UNDERRUN = 5;
  localparam int ST_MADI = 8;
  localparam int ST_SPEED = 16;

  // MADI channel capacity per framing and speed
  localparam logic [7:0] MADI_CH_56 = 8'h38;
  localparam logic [7:0] MADI_CH_56_DS = 8'h1c;
  localparam logic [7:0] MADI_CH_56_QS = 8'h0e;
  localparam logic [7:0] MADI_CH_64 = 8'h40;
  localparam logic [7:0] MADI_CH_64_DS = 8'h20;
  localparam logic [7:0] MADI_CH_64_QS = 8'h10;
endpackage

// [src/sample_mux_output_formatter.sv]
// Sample multiplex output formatter with input FIFO and APB registers
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

module sample_fifo #(
  parameter int W = 192,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  // Drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data,
  // Fill level
  output logic [$clog2(DEPTH):0] o_count
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("sample_fifo depth must be a power of two");
  end

  logic [W-1:0] mem [0:DEPTH-1];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire logic push = i_valid && o_ready;
  wire logic pop = o_valid && i_ready;

  assign o_count = wr_ptr - rd_ptr;
  assign o_ready = o_count != (AW + 1)'(DEPTH);
  assign o_valid = o_count != '0;
  assign o_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= wr_ptr + (AW + 1)'(push);
      rd_ptr <= rd_ptr + (AW + 1)'(pop);
    end
  end
endmodule

// Overview of operation
// RL1: Double rate runs the internal sample tick at twice the base rate.
// RL2: Internal samples stay 24 bits wide in every speed mode.
// RL3: Double wire AES line carries one channel, odd then even sample.
// RL4: Double rate multiplexes each channel over two optical slots automatically.
// RL5: Double rate: channels 1-4 on port 1 pairs, 5-8 on port 2.
// RL6: Optical frames keep running at the 44.1 or 48 kHz base rate.
// RL7: Quad rate spreads each channel over four slots, two per port.
// RL8: Quad rate delivers at most four channels over both optical ports.
// RL9: Quad rate AES output is single wire only, one channel per subframe.
// RL10: Status byte 0 bit 0 picks professional or consumer layout.
// RL11: Bit 1 flags non-audio; remaining fields follow the chosen layout.
// RL12: Audio sample bits sit identically in both status layouts.
// RL13: MADI carries up to 28 pairs, 56 channels.
// RL14: 64-channel MADI is limited to base rate; 32 channels at double.
// RL15: MADI payload stays at or below the 100 Mbit/s capacity.
// RL16: Four-way multiplex spreads consecutive samples over four slots.
// RL17: Multiplexing only moves samples; every sample passes unchanged.
// RL18: Earlier samples go on lower-numbered slots within each group.
module sample_mux_output_formatter #(
  parameter int CYC_441 = smux_pkg::CYC_441,
  parameter int CYC_48 = smux_pkg::CYC_48
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // APB slave
  input wire logic [11:0] i_paddr,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Internal sample frames, all eight channels
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [191:0] i_in_data,
  // Timing
  output logic o_sample_tick,
  // Optical multichannel ports
  output logic [191:0] o_opt1_data,
  output logic [191:0] o_opt2_data,
  output logic o_opt_strobe,
  // AES lines, subframe A in the low half
  output logic [191:0] o_aes_data,
  output logic o_aes_strobe,
  output logic [7:0] o_cs_byte0
);
  localparam int SW = smux_pkg::SAMPLE_W;
  localparam int FW = smux_pkg::NUM_CH * SW;
  localparam int CW = $clog2(smux_pkg::FIFO_DEPTH) + 1;

  // Quad divides the base period by four, so it must be at least eight
  if (CYC_441 >= 8192 || CYC_48 >= 8192 ||
      CYC_441 < 8 || CYC_48 < 8) begin : g_chk_div
    $error("base period counts out of range");
  end
  // The status word has five bits for the fill level
  if (CW > 5) begin : g_chk_cnt
    $error("FIFO fill level does not fit the status field");
  end
  if (SW != 24 || FW != 192) begin : g_chk_w
    $error("sample word must be 24 bits");
  end

  // Registers
  logic [5:0] ctrl;
  logic [13:0] cstat;
  logic underrun;

  // APB decode
  wire logic sel_ctrl = i_paddr == smux_pkg::ADDR_CTRL;
  wire logic sel_cstat = i_paddr == smux_pkg::ADDR_CSTAT;
  wire logic sel_status = i_paddr == smux_pkg::ADDR_STATUS;
  wire logic mapped = sel_ctrl || sel_cstat || sel_status;
  wire logic setup = i_psel && !i_penable;
  wire logic access = i_psel && i_penable;
  wire logic wr = access && i_pwrite && mapped;
  wire logic [31:0] wmask = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}},
                             {8{i_pstrb[1]}}, {8{i_pstrb[0]}}};
  wire logic [31:0] ctrl_w = ({26'h0, ctrl} & ~wmask) | (i_pwdata & wmask);
  wire logic [31:0] cstat_w = ({18'h0, cstat} & ~wmask) | (i_pwdata & wmask);
  wire logic ur_clr = wr && sel_status && i_pstrb[0] &&
                      i_pwdata[smux_pkg::ST_UNDERRUN];

  assign o_pready = 1'b1;
  assign o_pslverr = access && !mapped;

  // FIFO between the sample source and the frame builder
  logic fifo_valid;
  logic [FW-1:0] fifo_data;
  logic [CW-1:0] fifo_count;
  logic tick;

  sample_fifo #(
    .W(FW),
    .DEPTH(smux_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_valid(i_in_valid),
    .o_ready(o_in_ready),
    .i_data(i_in_data),
    .o_valid(fifo_valid),
    .i_ready(tick),
    .o_data(fifo_data),
    .o_count(fifo_count)
  );

  // Speed and rate are latched at a frame boundary or while disabled so that a
  // group never mixes two multiplex layouts
  smux_pkg::speed_t speed;
  logic base48;
  logic [1:0] slot;
  logic [1:0] last_slot;
  logic [12:0] div_cnt;
  logic frame_done;
  logic word_done;
  logic [1:0] word_slot;
  logic [FW-1:0] gather [0:smux_pkg::MAX_GROUP-1];

  wire logic enable = ctrl[smux_pkg::CTRL_EN];
  // Take a control write in the cycle it lands, so that enabling with a
  // new speed never starts with a single-speed group
  wire logic [5:0] ctrl_now = (wr && sel_ctrl) ? ctrl_w[5:0] : ctrl;
  wire logic [1:0] req_speed = ctrl_now[smux_pkg::CTRL_SPEED +: 2];
  wire logic is_double = speed == smux_pkg::SPEED_DOUBLE;
  wire logic is_quad = speed == smux_pkg::SPEED_QUAD;
  wire logic [12:0] base_period = base48 ? 13'(CYC_48) : 13'(CYC_441);
  wire logic [1:0] shift = is_quad ? 2'h2 : (is_double ? 2'h1 : 2'h0);
  wire logic [12:0] tick_period = base_period >> shift; // [RL1]
  // The division remainder lands on one gap per group: sample ticks are
  // slightly uneven, but the frame keeps the exact base period
  wire logic [12:0] tick_rem = base_period - (tick_period << shift);
  wire logic frame_end = tick && slot == last_slot;
  wire logic dwire = is_double && ctrl[smux_pkg::CTRL_DWIRE]; // [RL9]

  assign tick = enable && div_cnt == 13'h0000;
  assign last_slot = is_quad ? 2'h3 : (is_double ? 2'h1 : 2'h0);
  assign o_sample_tick = tick;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      speed <= smux_pkg::SPEED_SINGLE;
      base48 <= 1'b0;
    end else if (!enable || frame_end) begin
      case (req_speed)
        2'b01: speed <= smux_pkg::SPEED_DOUBLE;
        2'b10: speed <= smux_pkg::SPEED_QUAD;
        default: speed <= smux_pkg::SPEED_SINGLE;
      endcase
      base48 <= ctrl_now[smux_pkg::CTRL_BASE48];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_cnt <= 13'h0000;
      slot <= 2'h0;
      frame_done <= 1'b0;
      word_done <= 1'b0;
      word_slot <= 2'h0;
    end else begin
      frame_done <= frame_end; // [RL6]
      word_done <= tick;
      if (!enable) begin
        div_cnt <= 13'h0000;
        slot <= 2'h0;
      end else if (tick) begin
        div_cnt <= tick_period - 13'h0001 +
                   (frame_end ? tick_rem : 13'h0000); // [RL6]
        slot <= frame_end ? 2'h0 : slot + 2'h1;
        word_slot <= slot;
      end else begin
        div_cnt <= div_cnt - 13'h0001;
      end
    end
  end

  // An empty FIFO at a tick sends silence and raises a sticky flag
  always_ff @(posedge i_clk) begin
    if (tick) begin
      gather[slot] <= fifo_valid ? fifo_data : '0; // [RL2] [RL17]
    end
  end

  wire logic ur_set = tick && !fifo_valid;

  // Optical slot mapping: group of 1, 2 or 4 slots per channel
  logic [FW-1:0] next_opt1;
  logic [FW-1:0] next_opt2;

  for (genvar s = 0; s < smux_pkg::OPT_SLOTS; s++) begin : g_opt
    // Base: channel s; double: pairs; quad: quads, port 2 carries the rest
    wire logic [SW-1:0] b1 = gather[0][s*SW +: SW];
    wire logic [SW-1:0] d1 = gather[s%2][(s/2)*SW +: SW]; // [RL4] [RL18]
    wire logic [SW-1:0] d2 = gather[s%2][(4+s/2)*SW +: SW]; // [RL5]
    wire logic [SW-1:0] q1 = gather[s%4][(s/4)*SW +: SW]; // [RL7] [RL16]
    wire logic [SW-1:0] q2 = gather[s%4][(2+s/4)*SW +: SW]; // [RL8]
    assign next_opt1[s*SW +: SW] = is_quad ? q1 : (is_double ? d1 : b1);
    assign next_opt2[s*SW +: SW] = is_quad ? q2 :
                                   (is_double ? d2 : {SW{1'b0}});
  end

  // AES mapping: single wire pairs per tick, or double wire per frame
  logic [FW-1:0] next_aes;

  for (genvar j = 0; j < smux_pkg::AES_LINES; j++) begin : g_aes
    for (genvar b = 0; b < 2; b++) begin : g_sub
      wire logic [SW-1:0] single = gather[word_slot][(2*j+b)*SW +: SW];
      wire logic [SW-1:0] dbl = gather[b][j*SW +: SW]; // [RL3]
      assign next_aes[(2*j+b)*SW +: SW] = dwire ? dbl : single;
    end
  end

  wire logic aes_upd = dwire ? frame_done : word_done; // [RL9]

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_opt1_data <= '0;
      o_opt2_data <= '0;
      o_opt_strobe <= 1'b0;
      o_aes_data <= '0;
      o_aes_strobe <= 1'b0;
    end else begin
      o_opt_strobe <= frame_done;
      o_aes_strobe <= aes_upd;
      if (frame_done) begin
        o_opt1_data <= next_opt1;
        o_opt2_data <= next_opt2;
      end
      if (aes_upd) begin
        o_aes_data <= next_aes; // [RL12]
      end
    end
  end

  // Channel-status byte 0, laid out by the professional flag
  wire logic cs_pro = cstat[smux_pkg::CS_PRO];
  wire logic [7:0] cs_pro_byte = {cstat[smux_pkg::CS_PFREQ +: 2],
                                  cstat[smux_pkg::CS_PLOCK],
                                  cstat[smux_pkg::CS_PEMPH +: 3],
                                  cstat[smux_pkg::CS_NONAUDIO], 1'b1};
  wire logic [7:0] cs_con_byte = {cstat[smux_pkg::CS_CMODE +: 2],
                                  cstat[smux_pkg::CS_CEMPH +: 3],
                                  cstat[smux_pkg::CS_CCOPY],
                                  cstat[smux_pkg::CS_NONAUDIO], 1'b0};
  wire logic [7:0] next_cs = cs_pro ? cs_pro_byte : cs_con_byte; // [RL10]

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cs_byte0 <= 8'h00;
    end else begin
      o_cs_byte0 <= next_cs; // [RL11]
    end
  end

  // MADI channel capacity for the current framing and speed; the 64
  // channel frame only fits the payload at base rate
  wire logic madi64 = ctrl[smux_pkg::CTRL_MADI64];
  wire logic [7:0] madi_56 = is_quad ? smux_pkg::MADI_CH_56_QS :
                             (is_double ? smux_pkg::MADI_CH_56_DS :
                              smux_pkg::MADI_CH_56); // [RL13]
  wire logic [7:0] madi_64 = is_quad ? smux_pkg::MADI_CH_64_QS :
                             (is_double ? smux_pkg::MADI_CH_64_DS :
                              smux_pkg::MADI_CH_64); // [RL14]
  wire logic [7:0] madi_lim = madi64 ? madi_64 : madi_56; // [RL15]

  // Register read mux
  wire logic [31:0] status_word = {14'h0000, speed, madi_lim, 2'b00,
                                   underrun, 5'(fifo_count)};
  wire logic [31:0] next_prdata = sel_ctrl ? {26'h0, ctrl} :
                                  sel_cstat ? {18'h0, cstat} :
                                  sel_status ? status_word : 32'h0;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl <= smux_pkg::CTRL_RESET;
      cstat <= smux_pkg::CSTAT_RESET;
      underrun <= 1'b0;
      o_prdata <= 32'h0;
    end else begin
      if (setup && !i_pwrite) begin
        o_prdata <= next_prdata;
      end
      if (wr && sel_ctrl) begin
        ctrl <= ctrl_w[5:0];
      end
      if (wr && sel_cstat) begin
        cstat <= cstat_w[13:0];
      end
      // Set wins over a simultaneous clear
      underrun <= ur_set || (underrun && !ur_clr);
    end
  end
endmodule

`default_nettype wire

// [test/smux_chk.sv]
// Port-level assertions for the sample multiplex formatter
`timescale 1ns/10ps
`default_nettype none
module smux_chk #(
  parameter int CYC_441 = 16,
  parameter int CYC_48 = 12
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [11:0] i_paddr,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic o_pslverr,
  input wire logic i_in_valid,
  input wire logic o_in_ready,
  input wire logic o_sample_tick,
  input wire logic [191:0] o_opt1_data,
  input wire logic [191:0] o_opt2_data,
  input wire logic o_opt_strobe,
  input wire logic [191:0] o_aes_data,
  input wire logic o_aes_strobe,
  input wire logic [7:0] o_cs_byte0
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [4:0] fill;
  logic [15:0] gap;
  logic seen;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_sample_tick && fill != 5'h00;
  wire mapped = i_paddr inside {smux_pkg::ADDR_CTRL, smux_pkg::ADDR_CSTAT,
    smux_pkg::ADDR_STATUS};
  // Gap counts cycles since the last base frame strobe
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fill <= 5'h00;
      gap <= 16'h0000;
      seen <= 1'b0;
    end else begin
      fill <= fill + 5'(push) - 5'(pop);
      gap <= o_opt_strobe ? 16'h0001 : gap + 16'h0001;
      seen <= seen || o_opt_strobe;
    end
  end
  function automatic logic [7:0] cs_exp(logic [31:0] d);
    return d[0] ? d[7:0] : {d[13:8], d[1], 1'b0};
  endfunction
  sequence cs_wr;
    i_psel && i_penable && i_pwrite && i_paddr == smux_pkg::ADDR_CSTAT
      && i_pstrb == 4'hf;
  endsequence
  chk_err_decode: assert property (i_psel && i_penable |-> o_pslverr == !mapped)
    else $error("slave error decode wrong");
  chk_cs_layout: assert property (
    cs_wr |=> ##1 o_cs_byte0 == cs_exp($past(i_pwdata, 2)))
    else $error("status byte wrong");
  chk_fifo_ready: assert property (o_in_ready == (fill != 5'h10))
    else $error("fill ready wrong");
  chk_tick_pulse: assert property (o_sample_tick |=> !o_sample_tick)
    else $error("tick too long");
  chk_opt_tick: assert property (o_opt_strobe |-> $past(o_sample_tick, 2))
    else $error("optical strobe untimed");
  chk_aes_tick: assert property (o_aes_strobe |-> $past(o_sample_tick, 2))
    else $error("aes strobe untimed");
  chk_opt_hold: assert property (!o_opt_strobe |->
    $stable(o_opt1_data) && $stable(o_opt2_data))
    else $error("optical data moved");
  chk_aes_hold: assert property (!o_aes_strobe |-> $stable(o_aes_data))
    else $error("aes data moved");
  chk_base_frame: assert property (o_opt_strobe && seen |->
    gap inside {16'(CYC_441), 16'(CYC_48)})
    else $error("base frame length wrong");
endmodule
`default_nettype wire

// [test/smux_rx.sv]
// Receiver model on the optical and AES outputs
`timescale 1ns/10ps
`default_nettype none
module smux_rx (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tick,
  input wire logic [191:0] i_opt1,
  input wire logic [191:0] i_opt2,
  input wire logic i_opt_stb,
  input wire logic [191:0] i_aes,
  input wire logic i_aes_stb
);
  logic [191:0] opt1, opt2, aes;
  logic [7:0] n_opt, n_aes, ticks, run;
  // Only the first frame is kept: later ones carry underrun zeros
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {opt1, opt2, aes} <= '0;
      {n_opt, n_aes, ticks, run} <= '0;
    end else begin
      if (i_opt_stb && n_opt == 8'h00) begin
        opt1 <= i_opt1;
        opt2 <= i_opt2;
      end
      if (i_aes_stb && n_aes == 8'h00) begin
        aes <= i_aes;
      end
      n_opt <= n_opt + 8'(i_opt_stb);
      n_aes <= n_aes + 8'(i_aes_stb);
      run <= i_opt_stb ? 8'h00 : run + 8'(i_tick);
      if (i_opt_stb && n_opt == 8'h01) begin
        ticks <= run;
      end
    end
  end
endmodule
`default_nettype wire

// [test/tb_sample_mux_output_formatter.sv]
// Self-checking bench for the sample multiplex formatter
`timescale 1ns/10ps
`default_nettype none
module tb_sample_mux_output_formatter;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [31:0] i_pwdata = 32'h0;
  logic [3:0] i_pstrb = 4'hf;
  logic i_in_valid = 1'b0;
  logic [191:0] i_in_data = '0;
  logic [31:0] o_prdata, rd;
  logic o_pready, o_pslverr, o_in_ready, o_sample_tick, err;
  logic o_opt_strobe, o_aes_strobe;
  logic [191:0] o_opt1_data, o_opt2_data, o_aes_data;
  logic [7:0] o_cs_byte0;
  logic [31:0] modes [7] = '{32'h10, 32'h11, 32'h19, 32'h16, 32'h1a,
    32'h13, 32'h31};
  logic [31:0] cs [2] = '{32'h0000_00a5, 32'h0000_2a52};
  int failures = 0;
  int check_count = 0;
  always #2.5 i_clk = ~i_clk;
  sample_mux_output_formatter #(.CYC_441(16), .CYC_48(12)) dut_u (
    .i_clk, .i_rst_n, .i_paddr, .i_psel, .i_penable, .i_pwrite, .i_pwdata,
    .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .i_in_valid, .o_in_ready,
    .i_in_data, .o_sample_tick, .o_opt1_data, .o_opt2_data, .o_opt_strobe,
    .o_aes_data, .o_aes_strobe, .o_cs_byte0);
  smux_rx rx_u (.i_clk, .i_rst_n, .i_tick(o_sample_tick),
    .i_opt1(o_opt1_data), .i_opt2(o_opt2_data), .i_opt_stb(o_opt_strobe),
    .i_aes(o_aes_data), .i_aes_stb(o_aes_strobe));
  task automatic check(input logic [191:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    while (o_pready !== 1'b1) @(posedge i_clk);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask
  function automatic logic [23:0] smp(int n, int c);
    return {8'ha5, 8'(n), 8'(c)};
  endfunction
  task automatic push(int n);
    for (int f = 0; f < n; f++) begin
      for (int c = 0; c < 8; c++) i_in_data[24 * c +: 24] <= smp(f, c);
      i_in_valid <= 1'b1;
      @(posedge i_clk);
    end
    i_in_valid <= 1'b0;
  endtask
  // Each mode starts from reset so group alignment is known
  task automatic run(input logic [31:0] ctrl);
    logic [191:0] e1, e2, ea;
    int s, g, per;
    s = ctrl[1:0] == 2'h3 ? 0 : int'(ctrl[1:0]);
    g = 1 << s;
    per = 8 / g;
    e1 = '0;
    e2 = '0;
    for (int c = 0; c < (s == 0 ? 8 : 2 * per); c++) begin
      for (int k = 0; k < g; k++) begin
        if (c < per) e1[24 * (c * g + k) +: 24] = smp(k, c);
        else e2[24 * ((c - per) * g + k) +: 24] = smp(k, c);
      end
    end
    for (int j = 0; j < 4; j++) begin
      ea[48 * j +: 48] = (s == 1 && ctrl[3]) ? {smp(1, j), smp(0, j)}
        : {smp(0, 2 * j + 1), smp(0, 2 * j)};
    end
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    push(g);
    apb(1'b1, smux_pkg::ADDR_CTRL, ctrl);
    for (int t = 0; t < 300 && rx_u.n_opt < 8'h02; t++) @(posedge i_clk);
    check(rx_u.opt1, e1);
    check(rx_u.opt2, e2);
    check(rx_u.aes, ea);
    check(192'(rx_u.ticks), 192'(g));
    apb(1'b0, smux_pkg::ADDR_STATUS, 32'h0);
    check(192'(rd), 192'({s[1:0], (ctrl[5] ? 8'h40 : 8'h38) >> s,
      8'h20}));
  endtask
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    apb(1'b0, smux_pkg::ADDR_STATUS, 32'h0);
    check(192'(rd), 192'(32'h0000_3800));
    apb(1'b0, 12'h00c, 32'h0);
    check(192'({err, rd}), 192'({1'b1, 32'h0}));
    push(16);
    apb(1'b0, smux_pkg::ADDR_STATUS, 32'h0);
    check(192'({o_in_ready, rd}), 192'({1'b0, 32'h0000_3810}));
    foreach (modes[i]) run(modes[i]);
    foreach (cs[i]) begin
      apb(1'b1, smux_pkg::ADDR_CSTAT, cs[i]);
      apb(1'b0, smux_pkg::ADDR_CSTAT, 32'h0);
      check(192'({rd, o_cs_byte0}), 192'({cs[i], cs[i][0] ? cs[i][7:0]
        : {cs[i][13:8], cs[i][1], 1'b0}}));
    end
    // Stop the ticks, then clear the sticky underrun flag
    apb(1'b1, smux_pkg::ADDR_CTRL, 32'h0);
    apb(1'b1, smux_pkg::ADDR_STATUS, 32'h20);
    apb(1'b0, smux_pkg::ADDR_STATUS, 32'h0);
    check(192'(rd), 192'(32'h0000_3800));
    conclude();
  end
  initial begin
    #100us;
    failures++;
    conclude();
  end
endmodule
bind sample_mux_output_formatter smux_chk #(.CYC_441(CYC_441),
  .CYC_48(CYC_48)) chk_u (.i_clk, .i_rst_n, .i_paddr, .i_psel, .i_penable,
  .i_pwrite, .i_pwdata, .i_pstrb, .o_pslverr, .i_in_valid, .o_in_ready,
  .o_sample_tick, .o_opt1_data, .o_opt2_data, .o_opt_strobe, .o_aes_data,
  .o_aes_strobe, .o_cs_byte0);
`default_nettype wire
